// file: verilog/link_regs_cfg.svh
// constants for the link configuration and status register bank
// assumes byte-wide register port with 12-bit addresses
`ifndef LINK_REGS_CFG_SVH
`define LINK_REGS_CFG_SVH

`define ADDR_W               12
`define DATA_W               8
`define OFS_DEVICE_ID        12'h206
`define OFS_FRAME_COMMA      12'h207
`define OFS_LINK_STATUS      12'h208
`define OFS_CHANNEL_ENABLE   12'h209
`define OFS_LINK_CONTROL     12'h20a
`define RST_DEVICE_ID        8'h00
`define RST_FRAME_COMMA      8'h00
`define RST_CHANNEL_ENABLE   8'h03
`define RST_LINK_CONTROL     8'h00
`define COMMA_SEL_LSB        0
`define COMMA_SEL_MSB        1
`define ST_LINK_UP           6
`define ST_SYNC              5
`define ST_REALIGNED         4
`define ST_PHASE_SET         3
`define ST_SER_PLL           2
`define ST_CONV_PLL          0
`define CH_SINGLE            2
`define CH_SECOND            1
`define CH_FIRST             0
`define CTL_ENCODER_EN       0
`define CTL_ENC_8B10B        1
`define KCHAR_K28_7          8'hfc
`define KCHAR_K28_1          8'h3c
`define KCHAR_K28_5          8'hbc
`define LANES_FULL_DEFAULT   4'h8
`define CONV_FULL_DEFAULT    4'h4

`endif

// file: verilog/link_regs_pkg.sv
// types shared by the link configuration and status bank
// constants live in link_regs_cfg.svh
package link_regs_pkg;
   typedef enum logic [1:0] {
      comma_k28_7,
      comma_k28_1,
      comma_k28_5,
      comma_reserved
   } comma_sel_e;
endpackage

// file: verilog/level_sync.sv
// three-stage synchroniser for one asynchronous level
// assumes the input is quasi-static relative to core_clk_in
`timescale 1ns/1ps
module level_sync (
   input  wire logic core_clk_in,
   input  wire logic rst_in,
   input  wire logic async_in,
   output logic      level_out
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   // first stage feeds only the second
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end else begin
         s1_reg <= async_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // change accepted once stages two and three agree
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         level_out <= 1'b0;
      end else if (s2_reg == s3_reg) begin
         level_out <= s3_reg;
      end
   end
endmodule

// file: verilog/jesd_link_config_status.sv
// register bank for serial link configuration and status
// assumes a byte-wide register port, read data one cycle after the strobe;
// pll lock and sync levels arrive asynchronous, alignment events as one-cycle pulses
`timescale 1ns/1ps
`include "link_regs_cfg.svh"

// Notes on behaviour
// - the programmed 8-bit device identifier is sent in the second multiframe of lane alignment.
// - a 2-bit comma field picks K28.7, K28.1 or K28.5 for end of frame, code 3 reserved.
// - the end-of-frame character is inserted opportunistically and only in 8B/10B modes.
// - status bit 6 reads high while the link is up.
// - status bit 5 shows the sync level, 0 while a request is asserted.
// - status bit 4 sets on a sysref realignment and clears on a write of 1.
// - status bit 3 sets on the first sysref after encoder enable and clears on a write of 1.
// - status bit 2 reads high while the serializer pll is locked.
// - status bit 0 reads high while the converter pll is locked; bits 7 and 1 are reserved.
// - channel enable holds single at bit 2, second pair at 1, first pair at 0, reset 0x03.
// - single channel mode disables channels b, c and d and needs the first pair enabled.
// - with one pair off the link uses ceiling(lx/2) lanes and mx/2 converters, tail padded when lx is odd.
module jesd_link_config_status
   import link_regs_pkg::*;
#(
   parameter int ADDR_W = `ADDR_W,
   parameter int DATA_W = `DATA_W
) (
   input  wire logic              core_clk_in,
   input  wire logic              rst_in,
   input  wire logic [ADDR_W-1:0] addr_in,
   input  wire logic [DATA_W-1:0] wdata_in,
   input  wire logic              wr_in,
   input  wire logic              rd_in,
   output logic      [DATA_W-1:0] rdata_out,
   input  wire logic              link_up_in,
   input  wire logic              sync_n_in,
   input  wire logic              serializer_pll_lock_in,
   input  wire logic              converter_pll_lock_in,
   input  wire logic              sysref_realign_in,
   input  wire logic              sysref_event_in,
   input  wire logic [3:0]        lanes_full_in,
   input  wire logic [3:0]        converters_full_in,
   input  wire logic              ila_second_mf_in,
   input  wire logic              frame_end_slot_in,
   output logic      [7:0]        ila_device_id_out,
   output logic                   link_encoder_enable_out,
   output logic      [7:0]        frame_end_char_out,
   output logic                   frame_end_insert_out,
   output logic                   channel_a_enable_out,
   output logic                   channel_b_enable_out,
   output logic                   channel_c_enable_out,
   output logic                   channel_d_enable_out,
   output logic      [3:0]        lanes_used_out,
   output logic      [3:0]        converters_used_out,
   output logic                   tail_pad_out
);
   logic [7:0] link_device_identifier_reg;
   logic [1:0] frame_comma_select_reg;
   logic [2:0] channel_pair_enable_reg;
   logic       link_encoder_enable_reg;
   logic       enc_8b10b_reg;
   logic       realigned_reg;
   logic       multiframe_phase_set_flag_reg;
   logic       armed_reg;
   logic       link_up_sync;
   logic       sync_level_sync;
   logic       serializer_pll_lock;
   logic       converter_pll_lock;
   logic       single_channel_enable;
   logic       second_pair_enable;
   logic       first_pair_enable;
   logic       one_pair;
   logic       wr_status;
   logic       wr_device_id;
   logic       wr_frame_comma;
   logic       wr_channel_enable;
   logic       wr_link_control;
   logic [7:0] status_value;
   logic [7:0] rdata_next;
   logic [7:0] char_next;
   logic [3:0] lanes_next;
   logic [3:0] conv_next;
   comma_sel_e comma_sel;

   // asynchronous status levels
   level_sync u_sync_link (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .async_in    (link_up_in),
      .level_out   (link_up_sync)
   );
   level_sync u_sync_sync (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .async_in    (sync_n_in),
      .level_out   (sync_level_sync)
   );
   level_sync u_sync_spll (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .async_in    (serializer_pll_lock_in),
      .level_out   (serializer_pll_lock)
   );
   level_sync u_sync_cpll (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .async_in    (converter_pll_lock_in),
      .level_out   (converter_pll_lock)
   );

   // exact decode; unmapped offsets fall through untouched
   assign wr_status         = wr_in && (addr_in == `OFS_LINK_STATUS);
   assign wr_device_id      = wr_in && (addr_in == `OFS_DEVICE_ID);
   assign wr_frame_comma    = wr_in && (addr_in == `OFS_FRAME_COMMA);
   assign wr_channel_enable = wr_in && (addr_in == `OFS_CHANNEL_ENABLE);
   assign wr_link_control   = wr_in && (addr_in == `OFS_LINK_CONTROL);

   // identifier held; software keeps encoder off while writing
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         link_device_identifier_reg <= `RST_DEVICE_ID;
      end else if (wr_device_id) begin
         link_device_identifier_reg <= wdata_in[7:0];
      end
   end

   // comma field stored, upper bits read zero
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         frame_comma_select_reg <= 2'(`RST_FRAME_COMMA);
      end else if (wr_frame_comma) begin
         frame_comma_select_reg <= wdata_in[`COMMA_SEL_MSB:`COMMA_SEL_LSB];
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         channel_pair_enable_reg <= 3'(`RST_CHANNEL_ENABLE);
      end else if (wr_channel_enable) begin
         channel_pair_enable_reg <= wdata_in[2:0];
      end
   end

   // encoder enable lives in the control register
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         link_encoder_enable_reg <= 1'b0;
      end else if (wr_link_control) begin
         link_encoder_enable_reg <= wdata_in[`CTL_ENCODER_EN];
      end
   end

   // 8b/10b mode bit, read back in the control register and otherwise consulted only for end-of-frame insertion
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         enc_8b10b_reg <= 1'b0;
      end else if (wr_link_control) begin
         enc_8b10b_reg <= wdata_in[`CTL_ENC_8B10B];
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         realigned_reg <= 1'b0;
      end else if (sysref_realign_in) begin
         realigned_reg <= 1'b1;
      end else if (wr_status && wdata_in[`ST_REALIGNED]) begin
         realigned_reg <= 1'b0;
      end
   end

   // armed on encoder enable, fired by first sysref
   // re-arms while the encoder is off, so a re-enable waits for a fresh sysref
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         armed_reg <= 1'b0;
      end else if (!link_encoder_enable_reg) begin
         armed_reg <= 1'b1;
      end else if (sysref_event_in) begin
         armed_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         multiframe_phase_set_flag_reg <= 1'b0;
      end else if (link_encoder_enable_reg && armed_reg && sysref_event_in) begin
         multiframe_phase_set_flag_reg <= 1'b1;
      end else if (wr_status && wdata_in[`ST_PHASE_SET]) begin
         multiframe_phase_set_flag_reg <= 1'b0;
      end
   end

   // status built only from live state, never from write data
   always_comb begin
      status_value = 8'h00;
      status_value[`ST_LINK_UP] = link_up_sync;
      status_value[`ST_SYNC] = sync_level_sync;
      status_value[`ST_REALIGNED] = realigned_reg;
      status_value[`ST_PHASE_SET] = multiframe_phase_set_flag_reg;
      status_value[`ST_SER_PLL] = serializer_pll_lock;
      // converter lock, 7 and 1 zero
      status_value[`ST_CONV_PLL] = converter_pll_lock;
   end

   always_comb begin
      rdata_next = 8'h00;
      if (rd_in) begin
         case (addr_in)
            `OFS_DEVICE_ID:      rdata_next = link_device_identifier_reg;
            `OFS_FRAME_COMMA:    rdata_next = {6'h00, frame_comma_select_reg};
            `OFS_LINK_STATUS:    rdata_next = status_value;
            `OFS_CHANNEL_ENABLE: rdata_next = {5'h00, channel_pair_enable_reg};
            `OFS_LINK_CONTROL:   rdata_next = {6'h00, enc_8b10b_reg, link_encoder_enable_reg};
            default:             rdata_next = 8'h00;
         endcase
      end
   end

   // data valid only in the cycle after the read strobe
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_out <= 8'h00;
      end else begin
         rdata_out <= rdata_next;
      end
   end

   assign comma_sel = comma_sel_e'(frame_comma_select_reg);
   always_comb begin
      case (comma_sel)
         comma_k28_7: char_next = `KCHAR_K28_7;
         comma_k28_1: char_next = `KCHAR_K28_1;
         comma_k28_5: char_next = `KCHAR_K28_5;
         // reserved code falls back to the compliant character
         default:     char_next = `KCHAR_K28_7;
      endcase
   end

   assign single_channel_enable = channel_pair_enable_reg[`CH_SINGLE];
   assign second_pair_enable    = channel_pair_enable_reg[`CH_SECOND];
   assign first_pair_enable     = channel_pair_enable_reg[`CH_FIRST];
   assign one_pair = single_channel_enable || (first_pair_enable != second_pair_enable);

   always_comb begin
      if (one_pair) begin
         lanes_next = (lanes_full_in >> 1) + {3'h0, lanes_full_in[0]};
         conv_next  = converters_full_in >> 1;
      end else begin
         lanes_next = lanes_full_in;
         conv_next  = converters_full_in;
      end
   end

   // identifier presented for the second multiframe
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ila_device_id_out <= `RST_DEVICE_ID;
      end else if (ila_second_mf_in) begin
         ila_device_id_out <= link_device_identifier_reg;
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         frame_end_char_out <= `KCHAR_K28_7;
      end else begin
         frame_end_char_out <= char_next;
      end
   end

   // opportunistic end-of-frame, 8b/10b only
   // 64b/66b modes never see an insert, whatever the comma choice
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         frame_end_insert_out <= 1'b0;
      end else begin
         frame_end_insert_out <= frame_end_slot_in && enc_8b10b_reg && link_encoder_enable_reg;
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         link_encoder_enable_out <= 1'b0;
      end else begin
         link_encoder_enable_out <= link_encoder_enable_reg;
      end
   end

   // single mode keeps only channel a, and only with first pair set
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         channel_a_enable_out <= 1'b1;
         channel_b_enable_out <= 1'b1;
      end else begin
         channel_a_enable_out <= first_pair_enable;
         channel_b_enable_out <= first_pair_enable && !single_channel_enable;
      end
   end

   // second pair follows its enable unless single mode is on
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         channel_c_enable_out <= 1'b1;
         channel_d_enable_out <= 1'b1;
      end else begin
         channel_c_enable_out <= second_pair_enable && !single_channel_enable;
         channel_d_enable_out <= second_pair_enable && !single_channel_enable;
      end
   end

   // lane count, halved and rounded up with one pair
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         lanes_used_out <= `LANES_FULL_DEFAULT;
      end else begin
         lanes_used_out <= lanes_next;
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         converters_used_out <= `CONV_FULL_DEFAULT;
      end else begin
         converters_used_out <= conv_next;
      end
   end

   // tail padding only when an odd full count is halved
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         tail_pad_out <= 1'b0;
      end else begin
         tail_pad_out <= one_pair && lanes_full_in[0];
      end
   end
endmodule

// file: sim/link_regs_props.sv
// assertions on the ports of the link configuration and status bank
// assumes it is bound into every instance of jesd_link_config_status
`timescale 1ns/1ps
`include "link_regs_cfg.svh"
module link_regs_props #(
   parameter int ADDR_W = 12,
   parameter int DATA_W = 8
) (
   input wire logic              core_clk_in,
   input wire logic              rst_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [DATA_W-1:0] wdata_in,
   input wire logic              wr_in,
   input wire logic              rd_in,
   input wire logic [DATA_W-1:0] rdata_out,
   input wire logic [3:0]        lanes_full_in,
   input wire logic [3:0]        converters_full_in,
   input wire logic              ila_second_mf_in,
   input wire logic              frame_end_slot_in,
   input wire logic [7:0]        ila_device_id_out,
   input wire logic              link_encoder_enable_out,
   input wire logic [7:0]        frame_end_char_out,
   input wire logic              frame_end_insert_out,
   input wire logic              channel_a_enable_out,
   input wire logic              channel_b_enable_out,
   input wire logic              channel_c_enable_out,
   input wire logic              channel_d_enable_out,
   input wire logic [3:0]        lanes_used_out,
   input wire logic [3:0]        converters_used_out,
   input wire logic              tail_pad_out
);
   logic [4:0] lanes_sum;
   // rounding up needs the fifth bit when the full count is 15
   assign lanes_sum = {1'b0, lanes_full_in} + 5'h01;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   // a quiet cycle after the write lets either output latency pass
   comma_char_a: assert property ((wr_in && addr_in == `OFS_FRAME_COMMA) ##1 !(wr_in && addr_in == `OFS_FRAME_COMMA)
      |=> frame_end_char_out == ($past(wdata_in[1:0], 2) == 2'h1 ? `KCHAR_K28_1 :
      ($past(wdata_in[1:0], 2) == 2'h2 ? `KCHAR_K28_5 : `KCHAR_K28_7))) else $error("frame end char wrong");
   insert_gate_a: assert property (frame_end_insert_out |-> $past(frame_end_slot_in)
      && $past(link_encoder_enable_out)) else $error("end char inserted without slot");
   ila_id_a: assert property ((rd_in && addr_in == `OFS_DEVICE_ID) ##1 ila_second_mf_in
      |=> ila_device_id_out == $past(rdata_out)) else $error("alignment id differs");
   chan_enable_a: assert property ((wr_in && addr_in == `OFS_CHANNEL_ENABLE) ##1 !wr_in |=>
      {channel_a_enable_out, channel_b_enable_out, channel_c_enable_out, channel_d_enable_out} ==
      {$past(wdata_in[0], 2), $past(wdata_in[0], 2) & ~$past(wdata_in[2], 2),
      {2{$past(wdata_in[1], 2) & ~$past(wdata_in[2], 2)}}}) else $error("channel enables wrong");
   chan_reserved_a: assert property (rd_in && addr_in == `OFS_CHANNEL_ENABLE |=> rdata_out[7:3] == 5'h00)
      else $error("channel reserved bits set");
   half_link_a: assert property (((channel_a_enable_out ^ channel_c_enable_out) && $stable(lanes_full_in)
      && $stable(converters_full_in))[*4] |-> lanes_used_out == lanes_sum[4:1]
      && converters_used_out == (converters_full_in >> 1) && tail_pad_out == lanes_full_in[0])
      else $error("half link sizing wrong");
   full_link_a: assert property ((channel_a_enable_out && channel_c_enable_out && $stable(lanes_full_in)
      && $stable(converters_full_in))[*4] |-> lanes_used_out == lanes_full_in
      && converters_used_out == converters_full_in && !tail_pad_out) else $error("full link sizing wrong");
   status_reserved_a: assert property (rd_in && addr_in == `OFS_LINK_STATUS
      |=> rdata_out[7] == 1'b0 && rdata_out[1] == 1'b0) else $error("status reserved bits set");
   cover property (frame_end_insert_out);
   cover property (ila_second_mf_in && link_encoder_enable_out);
   cover property (channel_a_enable_out && !channel_b_enable_out);
endmodule
bind jesd_link_config_status link_regs_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) props (.*);

// file: sim/link_far_end.sv
// behavioural receiver at the far end of the serial link
// assumes the bank's encoder enable, end char and alignment id outputs
`timescale 1ns/1ps
module link_far_end (
   input  wire logic       core_clk_in,
   input  wire logic       rst_in,
   input  wire logic       encoder_on_in,
   input  wire logic       insert_in,
   input  wire logic [7:0] char_in,
   input  wire logic [7:0] id_in,
   output logic            sync_n_out,
   output logic            link_up_out,
   output logic            ila_mf2_out,
   output logic            slot_out,
   output logic [7:0]      seen_id_out = 8'h00,
   output logic [7:0]      seen_char_out = 8'h00
);
   logic [5:0] step_reg = 6'h00;
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in || !encoder_on_in)
         step_reg <= 6'h00;
      else if (step_reg != 6'h3f)
         step_reg <= step_reg + 6'h01;
   end
   assign sync_n_out = step_reg >= 6'h08;
   assign ila_mf2_out = step_reg >= 6'h0c && step_reg < 6'h10;
   assign link_up_out = step_reg >= 6'h14;
   assign slot_out = link_up_out && step_reg[1:0] == 2'h3;
   always_ff @(posedge core_clk_in) begin
      if (step_reg == 6'h12)
         seen_id_out <= id_in;
   end
   always_ff @(posedge core_clk_in) begin
      if (insert_in)
         seen_char_out <= char_in;
   end
endmodule

// file: sim/tb.sv
// self-checking bench for the link configuration and status bank
// assumes link_far_end drives the link side, the bound checker watches ports
`timescale 1ns/1ps
`include "link_regs_cfg.svh"
module tb;
   logic       core_clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0, sp, cp;
   logic       serializer_pll_lock_in = 1'b0, converter_pll_lock_in = 1'b0;
   logic       sysref_realign_in = 1'b0, sysref_event_in = 1'b0, link_up_in, sync_n_in;
   logic       ila_second_mf_in, frame_end_slot_in, link_encoder_enable_out, frame_end_insert_out;
   logic       channel_a_enable_out, channel_b_enable_out, channel_c_enable_out, channel_d_enable_out;
   logic       tail_pad_out;
   logic [11:0] addr_in = 12'h000;
   logic [7:0] wdata_in = 8'h00, rdata_out, ila_device_id_out, frame_end_char_out, seen_id, seen_char, got, id;
   logic [3:0] lanes_full_in = 4'h8, converters_full_in = 4'h4, lanes_used_out, converters_used_out, lx, mx;
   logic [7:0] ch_codes [4] = '{8'h03, 8'h01, 8'h02, 8'h05};
   int         err_total = 0, samples_checked = 0, inserts = 0;
   jesd_link_config_status DUT (.*);
   link_far_end far (.core_clk_in(core_clk_in), .rst_in(rst_in), .encoder_on_in(link_encoder_enable_out),
      .insert_in(frame_end_insert_out), .char_in(frame_end_char_out), .id_in(ila_device_id_out),
      .sync_n_out(sync_n_in), .link_up_out(link_up_in), .ila_mf2_out(ila_second_mf_in),
      .slot_out(frame_end_slot_in), .seen_id_out(seen_id), .seen_char_out(seen_char));
   always #5 core_clk_in = ~core_clk_in;
   always @(posedge core_clk_in) if (frame_end_insert_out === 1'b1) inserts++;
   function automatic logic [7:0] st(input logic up, sn, re, ph, s, c);
      return {1'b0, up, sn, re, ph, s, 1'b0, c};
   endfunction
   function automatic logic [7:0] link_exp(input logic [7:0] c, input logic [3:0] l, m);
      logic [4:0] sum;
      sum = {1'b0, l} + 5'h01;
      return (c[2] | (c[0] ^ c[1])) ? {sum[4:1], m >> 1} : {l, m};
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      rd_in <= 1'b0;
      @(posedge core_clk_in);
      wr_in <= 1'b0;
      @(posedge core_clk_in);
   endtask
   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      addr_in <= a;
      rd_in <= 1'b1;
      wr_in <= 1'b0;
      @(posedge core_clk_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
      @(posedge core_clk_in);
   endtask
   task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
      rd(a, got);
      check(got, exp);
   endtask
   task automatic pulse(input bit realign);
      if (realign)
         sysref_realign_in <= 1'b1;
      else
         sysref_event_in <= 1'b1;
      @(posedge core_clk_in);
      sysref_realign_in <= 1'b0;
      sysref_event_in <= 1'b0;
      cyc(2);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #200000;
      err_total++;
      finish_test();
   end
   initial begin
      void'($urandom(32'h51fc1ff6));
      cyc(8);
      rst_in <= 1'b0;
      cyc(1);
      rchk(`OFS_FRAME_COMMA, `RST_FRAME_COMMA);
      rchk(`OFS_CHANNEL_ENABLE, `RST_CHANNEL_ENABLE);
      wr(12'h20b, 8'hff);
      rchk(`OFS_LINK_STATUS, 8'h00);
      $display("test reset done");
      foreach (ch_codes[i]) begin
         lx = 4'($urandom_range(8, 1));
         mx = 4'($urandom_range(8, 2));
         lanes_full_in <= lx;
         converters_full_in <= mx;
         wr(`OFS_CHANNEL_ENABLE, ch_codes[i]);
         rd(`OFS_CHANNEL_ENABLE, got);
         cyc(4);
         check(got, ch_codes[i]);
         check({4'h0, channel_d_enable_out, channel_c_enable_out, channel_b_enable_out, channel_a_enable_out},
            {4'h0, {2{ch_codes[i][1] & ~ch_codes[i][2]}}, ch_codes[i][0] & ~ch_codes[i][2], ch_codes[i][0]});
         check({lanes_used_out, converters_used_out}, link_exp(ch_codes[i], lx, mx));
         check({7'h00, tail_pad_out}, {7'h00, lx[0] & (ch_codes[i][2] | ^ch_codes[i][1:0])});
      end
      $display("test channels done");
      for (int k = 0; k < 4; k++) begin
         wr(`OFS_FRAME_COMMA, 8'(k));
         rd(`OFS_FRAME_COMMA, got);
         cyc(2);
         check(got, 8'(k));
         check(frame_end_char_out, k == 1 ? `KCHAR_K28_1 : (k == 2 ? `KCHAR_K28_5 : `KCHAR_K28_7));
      end
      $display("test comma done");
      id = 8'($urandom);
      // identity and comma set while encoder off
      wr(`OFS_DEVICE_ID, id);
      wr(`OFS_FRAME_COMMA, 8'h01);
      wr(`OFS_LINK_CONTROL, 8'h03);
      repeat (30) rd(`OFS_DEVICE_ID, got);
      check({7'h00, link_encoder_enable_out}, 8'h01);
      check(got, id);
      check(seen_id, id);
      check(seen_char, `KCHAR_K28_1);
      rchk(`OFS_LINK_STATUS, st(1, 1, 0, 0, 0, 0));
      pulse(1'b0);
      rchk(`OFS_LINK_STATUS, st(1, 1, 0, 1, 0, 0));
      wr(`OFS_LINK_STATUS, 8'h08);
      pulse(1'b0);
      rchk(`OFS_LINK_STATUS, st(1, 1, 0, 0, 0, 0));
      pulse(1'b1);
      wr(`OFS_LINK_STATUS, 8'hef);
      rchk(`OFS_LINK_STATUS, st(1, 1, 1, 0, 0, 0));
      wr(`OFS_LINK_STATUS, 8'h10);
      rchk(`OFS_LINK_STATUS, st(1, 1, 0, 0, 0, 0));
      wr(`OFS_LINK_CONTROL, 8'h01);
      cyc(3);
      inserts = 0;
      cyc(20);
      check(8'(inserts), 8'h00);
      $display("test link done");
      wr(`OFS_LINK_CONTROL, 8'h00);
      for (int k = 0; k < 6; k++) begin
         sp = 1'($urandom);
         cp = 1'($urandom);
         serializer_pll_lock_in <= sp;
         converter_pll_lock_in <= cp;
         cyc(6);
         rchk(`OFS_LINK_STATUS, st(0, 0, 0, 0, sp, cp));
      end
      wr(`OFS_LINK_STATUS, 8'hff);
      rchk(`OFS_LINK_STATUS, st(0, 0, 0, 0, sp, cp));
      $display("test status done");
      // mid-run reset restores the defaults
      rst_in <= 1'b1;
      cyc(2);
      check({channel_d_enable_out, channel_c_enable_out, channel_b_enable_out, channel_a_enable_out,
         tail_pad_out, 3'h0}, 8'hf0);
      check({lanes_used_out, converters_used_out}, {`LANES_FULL_DEFAULT, `CONV_FULL_DEFAULT});
      check(ila_device_id_out, `RST_DEVICE_ID);
      rst_in <= 1'b0;
      cyc(1);
      rchk(`OFS_DEVICE_ID, `RST_DEVICE_ID);
      rchk(`OFS_CHANNEL_ENABLE, `RST_CHANNEL_ENABLE);
      rchk(`OFS_LINK_CONTROL, `RST_LINK_CONTROL);
      rchk(12'h20b, 8'h00);
      $display("test reset again done");
      finish_test();
   end
endmodule
